// file: verilog/pdt_pkg.sv
package pdt_pkg;
    // wait-state and timing field widths, in bits
    localparam int HIT_WS_W = 2;
    localparam int MISS_WS_W = 2;
    localparam int PRE_W = 2;
    localparam int CAS_W = 2;
    localparam int MUX_W = 3;
    localparam int ROM_WS_W = 4;
    localparam int CNT_W = 5;
    // reset values: predecessor fixed timing and map
    localparam logic [1:0] HIT_WS_RST = 2'h0;
    localparam logic [1:0] MISS_WS_RST = 2'h1;
    localparam logic [1:0] PRE_RST = 2'h1;
    localparam logic [1:0] CAS_RST = 2'h1;
    localparam logic [2:0] MUX_RST = 3'h2;
    localparam logic [3:0] ROM_WS_RST = 4'h1;
    localparam logic [2:0] MEM_EN_RST = 3'h5;
    localparam logic [5:0] ROM_LO_RST = 6'h38;
    localparam int PRE_BASE = 2;
    localparam int MISS_BASE = 1;
    localparam int ROM_BASE = 1;
    localparam int ROM_WS_MAX = 9;
    // address map
    localparam logic [31:0] SHADOW_LO = 32'h000a_0000;
    localparam logic [31:0] SHADOW_HI = 32'h000f_ffff;
    localparam int SHADOW_BLK_SH = 14;
    localparam int SHADOW_BLKS = 24;
    localparam int MEM_STEP_SH = 17;
    localparam int ROM_STEP_SH = 14;
    localparam logic [31:0] SPLIT_BASE = 32'h0008_0000;
    localparam logic [31:0] SPLIT_HIGH = 32'h0010_0000;
    localparam int ROW_LSB = 11;
    localparam int ROW_W = 10;

    typedef struct packed {
        logic [1:0] hit_ws;
        logic [1:0] miss_ws;
        logic miss_wr_less;
        logic [1:0] pre;
        logic [1:0] cas_hit;
        logic [1:0] cas_rd_miss;
        logic [1:0] cas_wr_miss;
        logic [2:0] mux_half;
        logic [1:0] ilv_mode;
        logic stagger_en;
        logic pipe_en;
        logic [2:0] mem_en_blocks;
        logic split_en;
        logic [5:0] rom_lo_blk;
        logic [3:0] rom_ws;
        logic [SHADOW_BLKS-1:0] shadow_en;
        logic [SHADOW_BLKS-1:0] shadow_wp;
        logic enhanced;
    } pdt_cfg_t;

    typedef struct packed {
        logic ads;
        logic [31:0] addr;
        logic wr;
        logic mio;
    } pdt_cyc_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE = 7'h02,
        ST_ROW = 7'h04,
        ST_CAS = 7'h08,
        ST_WAIT = 7'h10,
        ST_ROM = 7'h20,
        ST_REF = 7'h40
    } pdt_state_t;
endpackage

// file: verilog/pdt_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_decode (
    input wire pdt_pkg::pdt_cfg_t i_cfg,
    input wire logic [31:0] i_addr,
    input wire logic i_wr,
    output logic o_local,
    output logic o_rom
);
    logic [31:0] a;
    logic shadow_area;
    logic [4:0] blk;
    logic rom_area;
    always_comb begin
        a = i_addr;
        if (i_cfg.split_en && a >= pdt_pkg::SPLIT_BASE
                && a < pdt_pkg::SPLIT_HIGH) begin
            a = a + pdt_pkg::SPLIT_BASE;
        end
        // the split moves 512K-1M above 1M, so decode the moved address
        shadow_area = (a >= pdt_pkg::SHADOW_LO)
            && (a <= pdt_pkg::SHADOW_HI);
        blk = 5'((a - pdt_pkg::SHADOW_LO) >> pdt_pkg::SHADOW_BLK_SH);
        rom_area = shadow_area
            && a[19:14] >= i_cfg.rom_lo_blk;
        o_rom = 1'b0;
        o_local = 1'b0;
        if (shadow_area) begin
            if (i_cfg.shadow_en[blk]) begin
                o_local = !(i_wr && i_cfg.shadow_wp[blk]);
            end else begin
                o_rom = rom_area && !i_wr;
            end
        end else if (a < pdt_pkg::SHADOW_LO) begin
            o_local = 32'(a >> pdt_pkg::MEM_STEP_SH)
                < 32'(i_cfg.mem_en_blocks);
        end else begin
            o_local = 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verilog/pdt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_ctrl #(
    parameter int BANKS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pdt_pkg::pdt_cfg_t i_cfg,
    input wire logic i_cfg_we,
    input wire pdt_pkg::pdt_cyc_t i_cyc,
    input wire logic i_refresh,
    output logic [BANKS-1:0] o_ras_n,
    output logic o_cas_n,
    output logic [9:0] o_ma,
    output logic o_rdy_n,
    output logic o_na_n,
    output logic o_rom_cs_n,
    output logic o_sysbus
);
    typedef struct packed {
        pdt_pkg::pdt_state_t st;
        pdt_pkg::pdt_cfg_t cfg;
        logic [pdt_pkg::CNT_W-1:0] cnt;
        logic [pdt_pkg::CNT_W-1:0] ws;
        logic [BANKS-1:0][pdt_pkg::ROW_W-1:0] row;
        logic [BANKS-1:0] open;
        logic [1:0] bank;
        logic wr;
        logic [31:0] addr;
        logic [BANKS-1:0] ras_n;
        logic cas_n;
        logic [9:0] ma;
        logic rdy_n;
        logic na_n;
        logic rom_cs_n;
        logic sysbus;
        logic [1:0] ref_i;
    } st_t;
    st_t q, d;
    logic dec_local, dec_rom;

    pdt_decode u_dec (
        .i_cfg(q.cfg),
        .i_addr(i_cyc.addr),
        .i_wr(i_cyc.wr),
        .o_local(dec_local),
        .o_rom(dec_rom)
    );

    function automatic logic [1:0] bank_of(input logic [31:0] a,
            input logic [1:0] mode);
        case (mode)
            2'h1: bank_of = {1'b0, a[pdt_pkg::ROW_LSB]};
            2'h2: bank_of = a[pdt_pkg::ROW_LSB+1:pdt_pkg::ROW_LSB];
            default: bank_of = 2'h0;
        endcase
    endfunction

    function automatic logic [pdt_pkg::ROW_W-1:0] row_of(
            input logic [31:0] a, input logic [1:0] mode);
        logic [31:0] s;
        s = a >> (pdt_pkg::ROW_LSB + 32'(mode));
        row_of = s[pdt_pkg::ROW_W-1:0];
    endfunction

    always_comb begin
        logic [1:0] bk;
        logic [pdt_pkg::CNT_W-1:0] miss_ws;
        logic [3:0] rom_c;
        bk = bank_of(i_cyc.addr, q.cfg.ilv_mode);
        rom_c = q.cfg.rom_ws;
        if (rom_c > 4'(pdt_pkg::ROM_WS_MAX)) begin
            rom_c = 4'(pdt_pkg::ROM_WS_MAX);
        end
        miss_ws = 5'(q.cfg.miss_ws) + 5'(pdt_pkg::MISS_BASE);
        if (i_cyc.wr && q.cfg.miss_wr_less) begin
            miss_ws = miss_ws - 5'h1;
        end
        if (miss_ws == 5'h0) begin
            miss_ws = 5'h1;
        end
        d = q;
        d.rdy_n = 1'b1;
        d.sysbus = 1'b0;
        if (i_cfg_we) begin
            d.cfg = i_cfg;
        end
        if (!d.cfg.enhanced) begin
            d.cfg.ilv_mode = 2'h0;
        end
        if (q.cnt != 5'h0) begin
            d.cnt = q.cnt - 5'h1;
        end
        case (q.st)
            pdt_pkg::ST_IDLE: begin
                d.cas_n = 1'b1;
                d.rom_cs_n = 1'b1;
                d.na_n = 1'b1;
                if (i_refresh) begin
                    d.st = pdt_pkg::ST_REF;
                    d.open = '0;
                    d.ref_i = 2'h0;
                    d.cnt = 5'(q.cfg.pre) + 5'(pdt_pkg::PRE_BASE);
                    // open pages precharge first, else no refresh edge
                    d.ras_n = '1;
                end else if (i_cyc.ads && i_cyc.mio) begin
                    d.addr = i_cyc.addr;
                    d.wr = i_cyc.wr;
                    d.bank = bk;
                    if (dec_rom) begin
                        d.st = pdt_pkg::ST_ROM;
                        d.rom_cs_n = 1'b0;
                        d.cnt = 5'(rom_c) + 5'(pdt_pkg::ROM_BASE);
                    end else if (!dec_local) begin
                        d.sysbus = 1'b1;
                    end else if (q.open[bk] && q.row[bk]
                            == row_of(i_cyc.addr, q.cfg.ilv_mode)) begin
                        d.st = pdt_pkg::ST_CAS;
                        d.cnt = 5'(q.cfg.cas_hit);
                        d.ws = 5'(q.cfg.hit_ws);
                    end else begin
                        d.st = pdt_pkg::ST_PRE;
                        d.ras_n[bk] = 1'b1;
                        d.cnt = 5'(q.cfg.pre) + 5'(pdt_pkg::PRE_BASE);
                        d.ws = miss_ws;
                    end
                end
            end
            pdt_pkg::ST_PRE: begin
                d.ma = row_of(q.addr, q.cfg.ilv_mode);
                if (q.cnt <= 5'h1) begin
                    d.st = pdt_pkg::ST_ROW;
                    d.ras_n[q.bank] = 1'b0;
                    d.open[q.bank] = 1'b1;
                    d.row[q.bank] = row_of(q.addr, q.cfg.ilv_mode);
                    // whole-cycle approximation of half-step delay
                    d.cnt = 5'(q.cfg.mux_half >> 1);
                end
            end
            pdt_pkg::ST_ROW: begin
                if (q.cnt == 5'h0) begin
                    d.ma = q.addr[10:1];
                    d.st = pdt_pkg::ST_CAS;
                    d.cnt = 5'(q.wr ? q.cfg.cas_wr_miss
                        : q.cfg.cas_rd_miss);
                end
            end
            pdt_pkg::ST_CAS: begin
                d.ma = q.addr[10:1];
                if (q.cnt == 5'h0) begin
                    d.cas_n = 1'b0;
                    d.st = pdt_pkg::ST_WAIT;
                    d.cnt = q.ws;
                end
            end
            pdt_pkg::ST_WAIT: begin
                d.na_n = !(q.cfg.pipe_en && q.cnt <= 5'h1);
                if (q.cnt == 5'h0) begin
                    d.rdy_n = 1'b0;
                    d.cas_n = 1'b1;
                    d.st = pdt_pkg::ST_IDLE;
                end
            end
            pdt_pkg::ST_ROM: begin
                if (q.cnt == 5'h0) begin
                    d.rdy_n = 1'b0;
                    d.rom_cs_n = 1'b1;
                    d.st = pdt_pkg::ST_IDLE;
                end
            end
            pdt_pkg::ST_REF: begin
                if (q.cnt == 5'h0) begin
                    if (&q.ras_n) begin
                        d.ras_n = q.cfg.stagger_en ? ~BANKS'(1) : '0;
                        d.cnt = 5'(q.cfg.pre) + 5'(pdt_pkg::PRE_BASE);
                    end else if (q.cfg.stagger_en
                            && q.ref_i != 2'(BANKS - 1)) begin
                        d.ref_i = q.ref_i + 2'h1;
                        d.ras_n = ~(BANKS'(1) << (q.ref_i + 2'h1));
                        d.cnt = 5'(q.cfg.pre) + 5'(pdt_pkg::PRE_BASE);
                    end else begin
                        d.ras_n = '1;
                        d.st = pdt_pkg::ST_IDLE;
                    end
                end
            end
            default: d.st = pdt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
            q.st <= pdt_pkg::ST_IDLE;
            q.cfg.hit_ws <= pdt_pkg::HIT_WS_RST;
            q.cfg.miss_ws <= pdt_pkg::MISS_WS_RST;
            q.cfg.pre <= pdt_pkg::PRE_RST;
            q.cfg.cas_hit <= pdt_pkg::CAS_RST;
            q.cfg.cas_rd_miss <= pdt_pkg::CAS_RST;
            q.cfg.cas_wr_miss <= pdt_pkg::CAS_RST;
            q.cfg.mux_half <= pdt_pkg::MUX_RST;
            q.cfg.rom_ws <= pdt_pkg::ROM_WS_RST;
            q.cfg.mem_en_blocks <= pdt_pkg::MEM_EN_RST;
            q.cfg.pipe_en <= 1'b1;
            q.cfg.rom_lo_blk <= pdt_pkg::ROM_LO_RST;
            q.ras_n <= '1;
            q.cas_n <= 1'b1;
            q.rdy_n <= 1'b1;
            q.na_n <= 1'b1;
            q.rom_cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_ras_n = q.ras_n;
    assign o_cas_n = q.cas_n;
    assign o_ma = q.ma;
    assign o_rdy_n = q.rdy_n;
    assign o_na_n = q.na_n;
    assign o_rom_cs_n = q.rom_cs_n;
    assign o_sysbus = q.sysbus;
endmodule
`default_nettype wire

// file: verif/pdt_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_ctrl_sva #(
    parameter int BANKS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pdt_pkg::pdt_cfg_t i_cfg,
    input wire logic i_cfg_we,
    input wire pdt_pkg::pdt_cyc_t i_cyc,
    input wire logic i_refresh,
    input wire logic [BANKS-1:0] o_ras_n,
    input wire logic o_cas_n,
    input wire logic [9:0] o_ma,
    input wire logic o_rdy_n,
    input wire logic o_na_n,
    input wire logic o_rom_cs_n,
    input wire logic o_sysbus
);
    logic pipe_q;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // the loaded config is internal, so track the pipeline bit here
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pipe_q <= 1'b1;
        end else if (i_cfg_we) begin
            pipe_q <= i_cfg.pipe_en;
        end
    end
    sequence s_ready;
        $fell(o_rdy_n);
    endsequence
    sequence s_rom_open;
        $fell(o_rom_cs_n);
    endsequence
    AST_RDY_PULSE: assert property (s_ready |=> o_rdy_n)
        else $error("ready low too long");
    AST_NO_NA_NONPIPE: assert property (!pipe_q |-> o_na_n)
        else $error("next address in non-pipelined mode");
    AST_SYSBUS_PULSE: assert property (o_sysbus |=> !o_sysbus)
        else $error("system bus pulse too long");
    AST_SYSBUS_NO_DRAM: assert property (o_sysbus |-> o_cas_n)
        else $error("column strobe on system bus access");
    AST_ROM_NO_CAS: assert property (!o_rom_cs_n |-> o_cas_n)
        else $error("column strobe during rom cycle");
    AST_ROM_READY: assert property (s_rom_open |-> ##[1:16] s_ready)
        else $error("rom cycle without ready");
    AST_PRECHARGE: assert property ($rose(o_ras_n[0]) |=> o_ras_n[0])
        else $error("precharge shorter than two cycles");
    AST_CAS_NEEDS_RAS: assert property (!o_cas_n |-> !(&o_ras_n))
        else $error("column strobe without open row");
endmodule
bind pdt_ctrl pdt_ctrl_sva #(.BANKS(BANKS)) u_sva (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_cfg(i_cfg), .i_cfg_we(i_cfg_we), .i_cyc(i_cyc),
    .i_refresh(i_refresh), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
    .o_ma(o_ma), .o_rdy_n(o_rdy_n), .o_na_n(o_na_n),
    .o_rom_cs_n(o_rom_cs_n), .o_sysbus(o_sysbus));
`default_nettype wire

// file: verif/pdt_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdt_dram_model #(
    parameter int BANKS = 4
) (
    input wire logic i_clk,
    input wire logic [BANKS-1:0] i_ras_n,
    input wire logic i_cas_n,
    input wire logic [9:0] i_ma,
    output int o_pre_w,
    output int o_fall_at [BANKS],
    // one row geometry for every bank
    output logic [9:0] o_row [BANKS]
);
    int cyc = 0;
    int hi_w = 0;
    logic [BANKS-1:0] ras_q = '1;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        ras_q <= i_ras_n;
        hi_w <= i_ras_n[0] ? hi_w + 1 : 0;
        if (ras_q[0] && !i_ras_n[0]) begin
            o_pre_w <= hi_w;
        end
        for (int b = 0; b < BANKS; b++) begin
            if (ras_q[b] && !i_ras_n[b] && i_cas_n) begin
                o_fall_at[b] <= cyc;
                o_row[b] <= i_ma;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_page_dram_timing_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_page_dram_timing_ctrl;
    localparam logic [33:0] ROWS [8] = '{{32'h0000_0000, 2'h0},
        {32'h0005_fffe, 2'h0}, {32'h0006_0000, 2'h2}, {32'h0009_fffe, 2'h2},
        {32'h000d_4000, 2'h2}, {32'h000d_8000, 2'h1}, {32'h000e_4000, 2'h0},
        {32'h000f_fffe, 2'h1}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_we = 1'b0;
    logic refresh = 1'b0;
    pdt_pkg::pdt_cfg_t cfg = '0;
    pdt_pkg::pdt_cfg_t base, c;
    pdt_pkg::pdt_cyc_t cyc_in = '0;
    logic [3:0] ras_n;
    logic [9:0] ma;
    logic cas_n, rdy_n, na_n, rom_cs_n, sysbus, sb, rc;
    logic na_seen = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int pre_w, m0, h0, p0, r0, m, h, p;
    int fall_at [4];
    logic [9:0] row [4];
    pdt_ctrl #(.BANKS(4)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg),
        .i_cfg_we(cfg_we), .i_cyc(cyc_in), .i_refresh(refresh),
        .o_ras_n(ras_n), .o_cas_n(cas_n), .o_ma(ma), .o_rdy_n(rdy_n),
        .o_na_n(na_n), .o_rom_cs_n(rom_cs_n), .o_sysbus(sysbus));
    pdt_dram_model #(.BANKS(4)) u_dram (.i_clk(clk), .i_ras_n(ras_n),
        .i_cas_n(cas_n), .i_ma(ma), .o_pre_w(pre_w), .o_fall_at(fall_at),
        .o_row(row));
    always #20 clk = ~clk;
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (exp !== got) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic load(input pdt_pkg::pdt_cfg_t v);
        step();
        cfg = v;
        cfg_we = 1'b1;
        step();
        cfg_we = 1'b0;
    endtask
    // a system bus access ends with its pulse, not with ready
    task automatic access(input logic [31:0] a, input logic w, output int n);
        n = 0;
        sb = 1'b0;
        rc = 1'b0;
        step();
        cyc_in = '{ads: 1'b1, addr: a, wr: w, mio: 1'b1};
        step();
        cyc_in.ads = 1'b0;
        while (rdy_n !== 1'b0 && !sb && n < 40) begin
            sb = sb | (sysbus === 1'b1);
            rc = rc | (rom_cs_n === 1'b0);
            na_seen = na_seen | (na_n === 1'b0);
            step();
            n++;
        end
        na_seen = na_seen | (na_n === 1'b0);
        if (n == 40) check("ready", 0, n);
    endtask
    task automatic meas(input pdt_pkg::pdt_cfg_t v, input logic w,
                        output int lm, output int lh, output int lp);
        load(v);
        access(32'h0000_0000, 1'b0, lm);
        access(32'h0000_1000, w, lm);
        lp = pre_w;
        access(32'h0000_1002, w, lh);
    endtask
    task automatic results;
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) step();
        rst_n = 1'b1;
        base = '0;
        base.pipe_en = 1'b1;
        base.mem_en_blocks = 3'h3;
        base.rom_lo_blk = 6'h36;
        base.shadow_en = 24'h02_0000;
        base.enhanced = 1'b1;
        load(base);
        for (int i = 0; i < 8; i++) begin
            access(ROWS[i][33:2], 1'b0, m);
            check("decode", int'(ROWS[i][1:0]), int'({sb, rc}));
        end
        // a mid-run reset must bring back the predecessor map
        rst_n = 1'b0;
        repeat (2) step();
        rst_n = 1'b1;
        access(32'h000e_8000, 1'b0, m);
        check("reset rom", 1, int'({sb, rc}));
        check("reset rom wait", 3, m);
        access(32'h0009_fffe, 1'b0, m);
        check("reset local", 0, int'({sb, rc}));
        meas(base, 1'b0, m0, h0, p0);
        check("precharge", pdt_pkg::PRE_BASE, p0);
        check("row address", 10'h002, row[0]);
        c = base;
        c.hit_ws = 2'h3;
        meas(c, 1'b0, m, h, p);
        check("hit wait", h0 + 3, h);
        c = base;
        c.miss_ws = 2'h3;
        meas(c, 1'b0, m, h, p);
        check("miss wait", m0 + 3, m);
        meas(c, 1'b1, r0, h, p);
        c.miss_wr_less = 1'b1;
        meas(c, 1'b1, m, h, p);
        check("write miss", r0 - 1, m);
        c = base;
        c.miss_wr_less = 1'b1;
        meas(c, 1'b1, m, h, p);
        check("least miss wait", m0, m);
        c = base;
        c.pre = 2'h3;
        meas(c, 1'b0, m, h, p);
        check("precharge", pdt_pkg::PRE_BASE + 3, p);
        na_seen = 1'b0;
        access(32'h0000_1006, 1'b0, m);
        check("next address", 1, int'(na_seen));
        c = base;
        c.pipe_en = 1'b0;
        load(c);
        na_seen = 1'b0;
        access(32'h0000_1004, 1'b0, m);
        check("next address", 0, int'(na_seen));
        load(base);
        access(32'h000e_8000, 1'b0, r0);
        c = base;
        c.rom_ws = 4'h9;
        load(c);
        access(32'h000e_8000, 1'b0, m);
        check("rom wait", r0 + 9, m);
        c.rom_ws = 4'hf;
        load(c);
        access(32'h000e_8000, 1'b0, m);
        check("rom wait limit", r0 + pdt_pkg::ROM_WS_MAX, m);
        c.mem_en_blocks = 3'h0;
        load(c);
        access(32'h0000_0000, 1'b0, m);
        check("disabled", 1, int'(sb));
        c = base;
        c.shadow_wp = 24'h02_0000;
        load(c);
        access(32'h000e_4000, 1'b1, m);
        check("write protect", 2, int'({sb, rc}));
        access(32'h000e_4000, 1'b0, m);
        check("shadow read", 0, int'({sb, rc}));
        c = base;
        c.split_en = 1'b1;
        load(c);
        access(32'h0008_0000, 1'b0, m);
        check("split", 0, int'({sb, rc}));
        for (int s = 0; s < 2; s++) begin
            c = base;
            c.stagger_en = s[0];
            load(c);
            refresh = 1'b1;
            for (int k = 0; k < 20 && ras_n[3:1] === 3'h7; k++) step();
            check("refresh", 1, int'(ras_n[3:1] !== 3'h7));
            refresh = 1'b0;
            repeat (20) step();
            check("stagger", s, int'(fall_at[1] != fall_at[3]));
        end
        // interleave stays off until the enhanced set is switched on
        c = base;
        c.ilv_mode = 2'h1;
        c.enhanced = 1'b0;
        load(c);
        access(32'h0000_0800, 1'b0, m);
        check("no interleave", 4'he, ras_n);
        c.enhanced = 1'b1;
        load(c);
        access(32'h0000_0800, 1'b0, m);
        check("interleave", 4'hc, ras_n);
        results();
    end
    initial begin
        #2_000_000;
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
